// ===== rtl/wspmc_dev.sv
// Operation
// - wait exits on reset, NMI, LVD, peripheral
// - software zeroes peripheral levels for non-peripheral wake
// - stop-in-wait clear keeps peripheral clocks running
// - stop-in-wait set gates internally clocked peripherals
// - serial wakes wait; external clock if gated
// - converter wakes wait only single, clocks running
// - timer wakes wait; gated needs event or subclk
// - software sets levels, I flag, starts peripherals
// - service begins when acknowledged and clock restored
// - wait wake keeps clock source and division
// - stop turns off oscillators, cpu, peripheral clocks
// - externally clocked peripherals keep running in stop
// - stop wake: NMI, key, INT, external timer/serial
// - all-clocks-off write forces div8 and strong drive
// - software clears oscillation stop detect before stop
// - software leaves PLL and stops it before stop
// - wait instruction halts cpu clock, oscillators on
// - gated wait keeps only divided-by-32 sub clock
// - stop wake restores pre-stop source, main/oco div8
`timescale 1ns/1ps
module wspmc_dev (
    input  wire logic                  CORE_CLK,
    input  wire logic                  RESET_N,
    wspmc_if.dev                       bus,
    input  wire logic [wspmc_pkg::NPER-1:0] PERIPH_IRQ,
    input  wire logic                  NMI_REQ,
    input  wire logic                  LVD_REQ,
    input  wire logic                  SER_EXT_CLK,
    input  wire logic                  ADC_SINGLE_MODE,
    input  wire logic                  TIMER_EVENT_MODE,
    input  wire logic                  TIMER_SRC_SUBCLK32,
    output logic                       CPU_CLK_EN,
    output logic                       PERIPH_CLK_EN,
    output logic                       SUBCLK_DIV32_EN,
    output logic                       MAIN_OSC_EN,
    output logic                       SUB_OSC_EN,
    output logic                       OCO_EN,
    output logic                       PLL_EN,
    output wspmc_pkg::wspmc_src_e      CPU_CLK_SRC,
    output wspmc_pkg::wspmc_div_e      CPU_CLK_DIV,
    output logic                       MAIN_OSC_DRIVE_HIGH,
    output logic                       OSC_STOP_DETECT_EN,
    output wspmc_pkg::wspmc_mode_e     POWER_MODE
);
    import wspmc_pkg::*;

    typedef struct packed {
        logic       cpu_clk_en;
        logic       periph_clk_en;
        logic       subclk_div32_en;
        logic       osc_en;
        logic       pll_en;
        wspmc_src_e src;
        wspmc_div_e div;
    } wspmc_dout_s;

    typedef struct packed {
        wspmc_ctl_s   ctl;
        wspmc_mode_e  mode;
        logic         wake;
        wspmc_cause_e cause;
        wspmc_dout_s  out;
    } wspmc_dst_s;

    localparam wspmc_dout_s DOUT_RESET = '{
        cpu_clk_en:      1'b1,
        periph_clk_en:   1'b1,
        subclk_div32_en: 1'b1,
        osc_en:          1'b1,
        pll_en:          1'b0,
        src:             SRC_MAIN,
        div:             DIV_8
    };

    localparam wspmc_dst_s DST_RESET = '{
        ctl:   CTL_RESET,
        mode:  MODE_RUN,
        wake:  1'b0,
        cause: CAUSE_NONE,
        out:   DOUT_RESET
    };

    wspmc_dst_s        st;
    wspmc_dst_s        next_st;
    logic [NPER-1:0]   pend;
    logic [NPER-1:0]   wait_ok;
    logic [NPER-1:0]   stop_ok;
    logic              gated;

    assign gated = st.ctl.periph_clk_stop_in_wait;

    // per-source qualification of peripheral wake requests
    genvar i;
    generate
        for (i = 0; i < NPER; i++)
        begin : g_src
            // request counts only when enabled by a nonzero level and the I flag
            assign pend[i] = PERIPH_IRQ[i] && (bus.irq_level[i] != LVL_OFF) && bus.i_flag;
            if (i == IDX_SER)
            begin : g_ser
                assign wait_ok[i] = !gated || SER_EXT_CLK;
                assign stop_ok[i] = SER_EXT_CLK;
            end
            else if (i == IDX_ADC)
            begin : g_adc
                assign wait_ok[i] = !gated && ADC_SINGLE_MODE;
                assign stop_ok[i] = 1'b0;
            end
            else if (i == IDX_TMR)
            begin : g_tmr
                assign wait_ok[i] = !gated || TIMER_EVENT_MODE || TIMER_SRC_SUBCLK32;
                assign stop_ok[i] = TIMER_EVENT_MODE;
            end
            else
            begin : g_ext
                // key input and INT pins need no internal clock
                assign wait_ok[i] = 1'b1;
                assign stop_ok[i] = 1'b1;
            end
        end
    endgenerate

    function automatic wspmc_div_e eff_div(input wspmc_ctl_s c);
        wspmc_div_e d;
        d = DIV_1;
        if (c.cpu_src == SRC_SUB)
            d = DIV_1;
        else if (c.cpu_div8_select)
            d = DIV_8;
        else if (c.cpu_div == DSEL_2)
            d = DIV_2;
        else if (c.cpu_div == DSEL_4)
            d = DIV_4;
        else if (c.cpu_div == DSEL_16)
            d = DIV_16;
        return d;
    endfunction

    always_comb
    begin
        next_st      = st;
        next_st.wake = 1'b0;
        case (st.mode)
            MODE_RUN:
            begin
                if (bus.ctl_wr)
                begin
                    next_st.ctl = bus.ctl_wdata;
                    if (bus.ctl_wdata.all_clocks_off)
                    begin
                        next_st.ctl.cpu_div8_select     = 1'b1;
                        next_st.ctl.main_osc_drive_high = 1'b1;
                        next_st.mode                    = MODE_STOP;
                    end
                end
                else if (bus.wait_exec)
                begin
                    next_st.mode = MODE_WAIT;
                end
            end
            MODE_WAIT:
            begin
                // control settings untouched, so source and division resume as before
                if (NMI_REQ || LVD_REQ || |(pend & wait_ok))
                begin
                    next_st.mode  = MODE_RUN;
                    next_st.wake  = 1'b1;
                    next_st.cause = NMI_REQ ? CAUSE_NMI :
                                    (LVD_REQ ? CAUSE_LVD : CAUSE_PERIPH);
                end
            end
            MODE_STOP:
            begin
                if (NMI_REQ || LVD_REQ || |(pend & stop_ok))
                begin
                    next_st.mode               = MODE_RUN;
                    next_st.ctl.all_clocks_off = 1'b0;
                    next_st.wake               = 1'b1;
                    next_st.cause = NMI_REQ ? CAUSE_NMI :
                                    (LVD_REQ ? CAUSE_LVD : CAUSE_PERIPH);
                end
            end
            default:
            begin
                next_st.mode = MODE_RUN;
            end
        endcase

        // clock enables follow the mode being entered
        next_st.out.cpu_clk_en      = (next_st.mode == MODE_RUN);
        next_st.out.periph_clk_en   = (next_st.mode == MODE_RUN) ||
                                      ((next_st.mode == MODE_WAIT) &&
                                       !next_st.ctl.periph_clk_stop_in_wait);
        next_st.out.subclk_div32_en = (next_st.mode != MODE_STOP);
        next_st.out.osc_en          = (next_st.mode != MODE_STOP);
        next_st.out.pll_en          = next_st.ctl.pll_on && (next_st.mode != MODE_STOP);
        next_st.out.src             = next_st.ctl.cpu_src;
        next_st.out.div             = eff_div(next_st.ctl);
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            st <= DST_RESET;
        else
            st <= next_st;
    end

    assign bus.ctl_rdata        = st.ctl;
    assign bus.mode             = st.mode;
    assign bus.wake             = st.wake;
    assign bus.wake_cause       = st.cause;
    assign CPU_CLK_EN           = st.out.cpu_clk_en;
    assign PERIPH_CLK_EN        = st.out.periph_clk_en;
    assign SUBCLK_DIV32_EN      = st.out.subclk_div32_en;
    assign MAIN_OSC_EN          = st.out.osc_en;
    assign SUB_OSC_EN           = st.out.osc_en;
    assign OCO_EN               = st.out.osc_en;
    assign PLL_EN               = st.out.pll_en;
    assign CPU_CLK_SRC          = st.out.src;
    assign CPU_CLK_DIV          = st.out.div;
    assign MAIN_OSC_DRIVE_HIGH  = st.ctl.main_osc_drive_high;
    assign OSC_STOP_DETECT_EN   = st.ctl.osc_stop_detect_enable;
    assign POWER_MODE           = st.mode;

endmodule // wspmc_dev

// ===== rtl/wspmc_pkg.sv
package wspmc_pkg;

    // peripheral wake sources, one entry per interrupt group
    localparam int NPER    = 5;
    localparam int IDX_KEY = 0;
    localparam int IDX_INT = 1;
    localparam int IDX_SER = 2;
    localparam int IDX_ADC = 3;
    localparam int IDX_TMR = 4;

    localparam int          LVL_W   = 3;
    localparam logic [2:0]  LVL_OFF = 3'h0;

    // cpu divider field codes when the divide-by-8 select is clear
    localparam logic [1:0]  DSEL_1  = 2'h0;
    localparam logic [1:0]  DSEL_2  = 2'h1;
    localparam logic [1:0]  DSEL_4  = 2'h2;
    localparam logic [1:0]  DSEL_16 = 2'h3;

    typedef enum logic [1:0] {
        MODE_RUN  = 2'b00,
        MODE_WAIT = 2'b01,
        MODE_STOP = 2'b10
    } wspmc_mode_e;

    typedef enum logic [1:0] {
        SRC_MAIN = 2'b00,
        SRC_SUB  = 2'b01,
        SRC_OCO  = 2'b10
    } wspmc_src_e;

    typedef enum logic [2:0] {
        DIV_1  = 3'b000,
        DIV_2  = 3'b001,
        DIV_4  = 3'b010,
        DIV_8  = 3'b011,
        DIV_16 = 3'b100
    } wspmc_div_e;

    typedef enum logic [1:0] {
        CAUSE_NONE   = 2'b00,
        CAUSE_NMI    = 2'b01,
        CAUSE_LVD    = 2'b10,
        CAUSE_PERIPH = 2'b11
    } wspmc_cause_e;

    typedef logic [NPER-1:0][LVL_W-1:0] wspmc_lvl_t;

    typedef struct packed {
        logic       periph_clk_stop_in_wait;
        logic       all_clocks_off;
        logic       cpu_div8_select;
        logic       main_osc_drive_high;
        logic       osc_stop_detect_enable;
        logic       cpu_clk_pll_select;
        logic       pll_on;
        wspmc_src_e cpu_src;
        logic [1:0] cpu_div;
    } wspmc_ctl_s;

    localparam wspmc_ctl_s CTL_RESET = '{
        periph_clk_stop_in_wait: 1'b0,
        all_clocks_off:          1'b0,
        cpu_div8_select:         1'b1,
        main_osc_drive_high:     1'b1,
        osc_stop_detect_enable:  1'b0,
        cpu_clk_pll_select:      1'b0,
        pll_on:                  1'b0,
        cpu_src:                 SRC_MAIN,
        cpu_div:                 DSEL_1
    };

endpackage

// ===== rtl/wspmc_if.sv
`timescale 1ns/1ps
interface wspmc_if;
    import wspmc_pkg::*;

    logic         ctl_wr;
    wspmc_ctl_s   ctl_wdata;
    logic         wait_exec;
    logic         i_flag;
    wspmc_lvl_t   irq_level;
    wspmc_ctl_s   ctl_rdata;
    wspmc_mode_e  mode;
    logic         wake;
    wspmc_cause_e wake_cause;

    modport dev (
        input  ctl_wr,
        input  ctl_wdata,
        input  wait_exec,
        input  i_flag,
        input  irq_level,
        output ctl_rdata,
        output mode,
        output wake,
        output wake_cause
    );

    modport cpu (
        output ctl_wr,
        output ctl_wdata,
        output wait_exec,
        output i_flag,
        output irq_level,
        input  ctl_rdata,
        input  mode,
        input  wake,
        input  wake_cause
    );
endinterface

// ===== rtl/wspmc_cpu.sv
`timescale 1ns/1ps
module wspmc_cpu (
    input  wire logic                       CORE_CLK,
    input  wire logic                       RESET_N,
    wspmc_if.cpu                            bus,
    input  wire logic                       REQ_WAIT,
    input  wire logic                       REQ_STOP,
    input  wire logic [wspmc_pkg::NPER-1:0] WAKE_SEL,
    input  wire logic [2:0]                 WAKE_LEVEL,
    input  wire logic                       CFG_WR,
    input  wspmc_pkg::wspmc_ctl_s           CFG,
    output logic [wspmc_pkg::NPER-1:0]      PERIPH_START,
    output logic                            BUSY,
    output logic                            WOKE,
    output wspmc_pkg::wspmc_cause_e         WAKE_CAUSE
);
    import wspmc_pkg::*;

    typedef enum logic [3:0] {
        H_IDLE   = 4'b0000,
        H_OSCOFF = 4'b0001,
        H_PLLSRC = 4'b0010,
        H_PLLOFF = 4'b0011,
        H_PRIO   = 4'b0100,
        H_IEN    = 4'b0101,
        H_START  = 4'b0110,
        H_ISSUE  = 4'b0111,
        H_SLEEP  = 4'b1000
    } wspmc_hstate_e;

    typedef struct packed {
        wspmc_hstate_e st;
        wspmc_ctl_s    ctl;
        logic          ctl_wr;
        logic          wait_exec;
        logic          i_flag;
        wspmc_lvl_t    lvl;
        logic [NPER-1:0] start;
        logic [NPER-1:0] sel;
        logic          stop_req;
        logic          busy;
        logic          woke;
        wspmc_cause_e  cause;
    } wspmc_hst_s;

    localparam wspmc_hst_s HST_RESET = '{
        st: H_IDLE, ctl: CTL_RESET, ctl_wr: 1'b0, wait_exec: 1'b0, i_flag: 1'b0,
        lvl: '0, start: '0, sel: '0, stop_req: 1'b0, busy: 1'b0, woke: 1'b0,
        cause: CAUSE_NONE
    };

    wspmc_hst_s h;
    wspmc_hst_s next_h;

    always_comb
    begin
        next_h           = h;
        next_h.ctl_wr    = 1'b0;
        next_h.wait_exec = 1'b0;
        next_h.woke      = 1'b0;
        case (h.st)
            H_IDLE:
            begin
                if (CFG_WR)
                begin
                    next_h.ctl                = CFG;
                    next_h.ctl.all_clocks_off = 1'b0;
                    next_h.ctl_wr             = 1'b1;
                end
                else if (REQ_WAIT || REQ_STOP)
                begin
                    next_h.stop_req = REQ_STOP;
                    next_h.sel      = WAKE_SEL;
                    next_h.st       = H_OSCOFF;
                end
            end
            H_OSCOFF:
            begin
                if (h.stop_req && h.ctl.osc_stop_detect_enable)
                begin
                    next_h.ctl.osc_stop_detect_enable = 1'b0;
                    next_h.ctl_wr                     = 1'b1;
                end
                next_h.st = H_PLLSRC;
            end
            H_PLLSRC:
            begin
                if (h.ctl.cpu_clk_pll_select)
                begin
                    next_h.ctl.cpu_clk_pll_select = 1'b0;
                    next_h.ctl.cpu_src            = SRC_MAIN;
                    next_h.ctl_wr                 = 1'b1;
                end
                next_h.st = H_PLLOFF;
            end
            H_PLLOFF:
            begin
                if (h.ctl.pll_on)
                begin
                    next_h.ctl.pll_on = 1'b0;
                    next_h.ctl_wr     = 1'b1;
                end
                next_h.st = H_PRIO;
            end
            H_PRIO:
            begin
                for (int k = 0; k < NPER; k++)
                begin
                    next_h.lvl[k] = h.sel[k] ? WAKE_LEVEL : LVL_OFF;
                end
                next_h.st = H_IEN;
            end
            H_IEN:
            begin
                next_h.i_flag = |h.sel;
                next_h.st     = H_START;
            end
            H_START:
            begin
                next_h.start = h.sel;
                next_h.st    = H_ISSUE;
            end
            H_ISSUE:
            begin
                if (h.stop_req)
                begin
                    next_h.ctl.all_clocks_off = 1'b1;
                    next_h.ctl_wr             = 1'b1;
                end
                else
                begin
                    next_h.wait_exec = 1'b1;
                end
                next_h.st = H_SLEEP;
            end
            H_SLEEP:
            begin
                // the device rewrites divider and drive on stop, so resync the copy
                if (bus.wake)
                begin
                    next_h.ctl   = bus.ctl_rdata;
                    next_h.woke  = 1'b1;
                    next_h.cause = bus.wake_cause;
                    next_h.st    = H_IDLE;
                end
            end
            default:
            begin
                next_h.st = H_IDLE;
            end
        endcase
        next_h.busy = (next_h.st != H_IDLE);
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            h <= HST_RESET;
        else
            h <= next_h;
    end

    assign bus.ctl_wr    = h.ctl_wr;
    assign bus.ctl_wdata = h.ctl;
    assign bus.wait_exec = h.wait_exec;
    assign bus.i_flag    = h.i_flag;
    assign bus.irq_level = h.lvl;
    assign PERIPH_START  = h.start;
    assign BUSY          = h.busy;
    assign WOKE          = h.woke;
    assign WAKE_CAUSE    = h.cause;

endmodule // wspmc_cpu

// ===== dv/wspmc_assertions.sv
`timescale 1ns/1ps
module wspmc_assertions (
    input wire logic                   CORE_CLK,
    input wire logic                   RESET_N,
    input wire logic                   ctl_wr,
    input wire wspmc_pkg::wspmc_ctl_s  ctl_wdata,
    input wire logic                   wait_exec,
    input wire logic                   i_flag,
    input wire wspmc_pkg::wspmc_lvl_t  irq_level,
    input wire wspmc_pkg::wspmc_ctl_s  ctl_rdata,
    input wire wspmc_pkg::wspmc_mode_e mode,
    input wire logic                   wake,
    input wire wspmc_pkg::wspmc_cause_e wake_cause
);
    import wspmc_pkg::*;

    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    a_stop_entry: assert property (ctl_wr && ctl_wdata.all_clocks_off && mode == MODE_RUN
        |=> mode == MODE_STOP) else $error("stop not entered after clocks-off write");
    a_stop_forces: assert property (ctl_wr && ctl_wdata.all_clocks_off && mode == MODE_RUN
        |=> ctl_rdata.cpu_div8_select && ctl_rdata.main_osc_drive_high)
        else $error("divide-by-8 or strong drive not forced on stop entry");
    a_wait_entry: assert property (wait_exec && !ctl_wr && mode == MODE_RUN
        |=> mode == MODE_WAIT) else $error("wait not entered");
    a_wake_to_run: assert property (wake |-> mode == MODE_RUN && $past(mode) != MODE_RUN)
        else $error("wake pulse without leaving sleep");
    a_run_needs_wake: assert property (mode == MODE_RUN && $past(mode) != MODE_RUN |-> wake)
        else $error("sleep left without wake pulse");
    a_wait_clk_kept: assert property (wake && $past(mode) == MODE_WAIT
        |-> ctl_rdata == $past(ctl_rdata)) else $error("clock setting changed by wait wake");
    a_stop_src_kept: assert property (wake && $past(mode) == MODE_STOP
        |-> !ctl_rdata.all_clocks_off && ctl_rdata.cpu_src == $past(ctl_rdata.cpu_src))
        else $error("clock source not restored after stop wake");
    a_periph_armed: assert property (wake && wake_cause == CAUSE_PERIPH
        |-> $past(i_flag) && $past(irq_level) != '0) else $error("peripheral wake while disarmed");
    a_wake_single: assert property (wake |=> !wake [*4])
        else $error("wake pulse repeated");
endmodule // wspmc_assertions

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import wspmc_pkg::*;

    // stop, stop-in-wait, source index, qualifiers, expected wake
    localparam logic [7:0] CASES [20] = '{8'h01, 8'h09, 8'h11, 8'h1B, 8'h18, 8'h21, 8'h41,
        8'h50, 8'h53, 8'h5A, 8'h60, 8'h63, 8'h65, 8'h81, 8'h89, 8'h90, 8'h93, 8'h9A, 8'hA3, 8'hA4};

    logic            clk;
    logic            rst_n;
    logic [NPER-1:0] irq;
    logic            nmi;
    logic            lvd;
    logic [3:0]      qual;
    logic            req_wait;
    logic            req_stop;
    logic [NPER-1:0] wake_sel;
    logic [2:0]      wake_lvl;
    logic            cfg_wr;
    wspmc_ctl_s      cfg;
    logic            cpu_en;
    logic            per_en;
    logic            sub32_en;
    logic            osc_en;
    logic            pll_en;
    logic            drive_high;
    logic            det_en;
    wspmc_src_e      clk_src;
    wspmc_div_e      clk_div;
    wspmc_mode_e     pmode;
    logic [NPER-1:0] pstart;
    logic            busy;
    wspmc_cause_e    cause;
    logic            woke;
    logic            sub_osc_en;
    logic            oco_en;
    int              woke_count = 0;
    int              fail_count = 0;
    int              comparisons = 0;
    int              cycles = 0;
    int              k;
    int              t;

    wspmc_if bus ();

    wspmc_dev i_wspmc_dev (.CORE_CLK(clk), .RESET_N(rst_n), .bus(bus.dev), .PERIPH_IRQ(irq),
        .NMI_REQ(nmi), .LVD_REQ(lvd), .SER_EXT_CLK(qual[0]), .ADC_SINGLE_MODE(qual[1]),
        .TIMER_EVENT_MODE(qual[2]), .TIMER_SRC_SUBCLK32(qual[3]), .CPU_CLK_EN(cpu_en),
        .PERIPH_CLK_EN(per_en), .SUBCLK_DIV32_EN(sub32_en), .MAIN_OSC_EN(osc_en),
        .SUB_OSC_EN(sub_osc_en), .OCO_EN(oco_en), .PLL_EN(pll_en), .CPU_CLK_SRC(clk_src),
        .CPU_CLK_DIV(clk_div),
        .MAIN_OSC_DRIVE_HIGH(drive_high), .OSC_STOP_DETECT_EN(det_en), .POWER_MODE(pmode));

    wspmc_cpu i_wspmc_cpu (.CORE_CLK(clk), .RESET_N(rst_n), .bus(bus.cpu), .REQ_WAIT(req_wait),
        .REQ_STOP(req_stop), .WAKE_SEL(wake_sel), .WAKE_LEVEL(wake_lvl), .CFG_WR(cfg_wr),
        .CFG(cfg), .PERIPH_START(pstart), .BUSY(busy), .WOKE(woke), .WAKE_CAUSE(cause));

    wspmc_assertions i_wspmc_assertions (.CORE_CLK(clk), .RESET_N(rst_n), .ctl_wr(bus.ctl_wr),
        .ctl_wdata(bus.ctl_wdata), .wait_exec(bus.wait_exec), .i_flag(bus.i_flag),
        .irq_level(bus.irq_level), .ctl_rdata(bus.ctl_rdata), .mode(bus.mode),
        .wake(bus.wake), .wake_cause(bus.wake_cause));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            $display("Error at %0t: run timed out", $time);
            test_done();
        end
    end

    // count acknowledged wakes seen by the cpu end
    always @(negedge clk)
    begin
        if (woke === 1'b1)
            woke_count++;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_idle();
        for (k = 0; k < 40 && busy !== 1'b0; k++)
            @(negedge clk);
    endtask

    // sleep, try one peripheral source, fall back to nmi/lvd when it must not wake
    task automatic scen(input logic stop, input logic psw, input int idx, input logic [1:0] q,
                        input logic [2:0] lvl, input wspmc_src_e src, input logic [1:0] alt,
                        input logic [1:0] dsel, input logic exp);
        wspmc_mode_e sm;
        wspmc_div_e  ediv;
        sm   = stop ? MODE_STOP : MODE_WAIT;
        ediv = (dsel == DSEL_1) ? DIV_1 : (dsel == DSEL_2) ? DIV_2 :
               (dsel == DSEL_4) ? DIV_4 : DIV_16;
        if (src == SRC_SUB)
            ediv = DIV_1;
        else if (stop)
            ediv = DIV_8;
        wait_idle();
        // pll select only with the main clock, else the cpu end falls back to main
        cfg    = '{psw, 1'h0, 1'h0, 1'h0, 1'h1, src == SRC_MAIN, 1'h1, src, dsel};
        cfg_wr = 1'h1;
        @(negedge clk);
        cfg_wr   = 1'h0;
        qual     = {q[1], q[0], q[0], q[0]};
        wake_sel = 5'h01 << idx;
        wake_lvl = lvl;
        wait_idle();
        req_stop = stop;
        req_wait = !stop;
        @(negedge clk);
        req_stop = 1'h0;
        req_wait = 1'h0;
        for (k = 0; k < 20 && pmode === MODE_RUN; k++)
            @(negedge clk);
        check(pmode, sm);
        check(cpu_en, 8'h00);
        check(per_en, !stop && !psw);
        check(sub32_en, !stop);
        check(osc_en, !stop);
        check({sub_osc_en, oco_en}, stop ? 8'h00 : 8'h03);
        check(pll_en, 8'h00);
        if (stop)
            check({drive_high, det_en}, 8'h02);
        if (lvl != 3'h0)
            check(pstart, 5'h01 << idx);
        irq[idx] = 1'h1;
        repeat (3) @(negedge clk);
        check(pmode, exp ? MODE_RUN : sm);
        irq = '0;
        if (!exp)
        begin
            {lvd, nmi} = alt;
            repeat (3) @(negedge clk);
            {lvd, nmi} = 2'h0;
        end
        wait_idle();
        @(negedge clk);
        check(cause, exp ? CAUSE_PERIPH : (alt[0] ? CAUSE_NMI : CAUSE_LVD));
        check(clk_div, ediv);
        check(clk_src, src);
        $display("test done: stop %0d source %0d wake %0d", stop, idx, exp);
    endtask

    initial
    begin
        rst_n    = 1'h0;
        irq      = '0;
        {lvd, nmi} = 2'h0;
        qual     = 4'h0;
        req_wait = 1'h0;
        req_stop = 1'h0;
        wake_sel = '0;
        wake_lvl = 3'h0;
        cfg_wr   = 1'h0;
        cfg      = CTL_RESET;
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        check(clk_div, DIV_8);
        check(drive_high, 8'h01);
        for (t = 0; t < 20; t++)
            scen(CASES[t][7], CASES[t][6], int'(CASES[t][5:3]), CASES[t][2:1], 3'h3, SRC_MAIN,
                 2'h1, t[1:0], CASES[t][0]);
        scen(1'h0, 1'h0, IDX_KEY, 2'h0, 3'h0, SRC_MAIN, 2'h1, DSEL_2, 1'h0);
        scen(1'h1, 1'h0, IDX_KEY, 2'h0, 3'h3, SRC_SUB, 2'h1, DSEL_2, 1'h1);
        scen(1'h1, 1'h0, IDX_INT, 2'h0, 3'h3, SRC_OCO, 2'h1, DSEL_2, 1'h1);
        scen(1'h1, 1'h0, IDX_ADC, 2'h1, 3'h3, SRC_MAIN, 2'h3, DSEL_2, 1'h0);
        scen(1'h0, 1'h1, IDX_ADC, 2'h1, 3'h3, SRC_MAIN, 2'h2, DSEL_2, 1'h0);
        check(woke_count[7:0], 8'h19);
        // reset while asleep must restore defaults, not resume
        req_wait = 1'h1;
        @(negedge clk);
        req_wait = 1'h0;
        for (k = 0; k < 20 && pmode === MODE_RUN; k++)
            @(negedge clk);
        check(pmode, MODE_WAIT);
        rst_n = 1'h0;
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        check(pmode, MODE_RUN);
        check(clk_div, DIV_8);
        check(cpu_en, 8'h01);
        check(busy, 8'h00);
        $display("test done: reset while asleep");
        test_done();
    end
endmodule // testbench
